// [include/epv_map.svh]
// offsets, field positions, reset values and timing counts
`ifndef EPV_MAP_SVH
`define EPV_MAP_SVH
`define EPV_ADDR_W        12
`define EPV_DATA_W        8
`define EPV_OFF_CTRL      12'h000
`define EPV_OFF_STATUS    12'h004
`define EPV_OFF_PCOUNT    12'h008
`define EPV_CTRL_ERASE    0
`define EPV_CTRL_INHIBIT  1
`define EPV_ST_SEC1       0
`define EPV_ST_SEC2       1
`define EPV_ST_ENC        2
`define EPV_ST_ERASING    3
`define EPV_ST_TERR       4
`define EPV_ST_PULSE_LSB  8
`define EPV_ST_MODE_LSB   16
`define EPV_CTRL_RESET    32'h0000_0000
`define EPV_SIG_LO_ADDR   12'h030
`define EPV_SIG_HI_ADDR   12'h031
`define EPV_ENC_LAST      12'h01F
`define EPV_PULSES        25
`define EPV_ERASED        8'hFF
`define EPV_CLK_NS        8
`define EPV_PGM_MIN_US    90
`define EPV_PGM_MAX_US    110
`define EPV_GAP_MIN_US    10
`define EPV_PGM_MIN_CYC   ((`EPV_PGM_MIN_US*1000+`EPV_CLK_NS-1)/`EPV_CLK_NS)
`define EPV_PGM_MAX_CYC   ((`EPV_PGM_MAX_US*1000)/`EPV_CLK_NS)
`define EPV_GAP_MIN_CYC   ((`EPV_GAP_MIN_US*1000+`EPV_CLK_NS-1)/`EPV_CLK_NS)
`endif

// [include/epv_pkg.sv]
// types shared by the eprom program and verify port
package epv_pkg;
  typedef enum logic [2:0] {
    EPV_IDLE,
    EPV_SIG,
    EPV_PGM_CODE,
    EPV_VERIFY,
    EPV_PGM_ENC,
    EPV_PGM_SEC1,
    EPV_PGM_SEC2
  } epv_mode_t;

  typedef struct packed {
    logic        reset_pin;
    logic        program_store_enable_pin_n;
    logic        program_strobe_pin_n;
    logic        vpp_present;
    logic        verify_enable_pin;
    logic        mode_select_a;
    logic        mode_select_b;
    logic        mode_select_c;
    logic [11:0] addr;
    logic [7:0]  data;
  } epv_pins_t;
endpackage : epv_pkg

// [hw/epv_port.sv]
// eprom program and verify port with apb status and control
`timescale 1ns/100ps
`include "epv_map.svh"
module epv_port #(
  parameter int unsigned   PGM_MIN_CYC = `EPV_PGM_MIN_CYC,
  parameter int unsigned   PGM_MAX_CYC = `EPV_PGM_MAX_CYC,
  parameter int unsigned   GAP_MIN_CYC = `EPV_GAP_MIN_CYC,
  parameter int unsigned   PULSES      = `EPV_PULSES,
  // identity bytes: values arbitrary
  parameter logic [7:0]    SIG_LO      = 8'hA5,
  parameter logic [7:0]    SIG_HI      = 8'h5A
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_pin,
  input  wire logic        program_store_enable_pin_n,
  input  wire logic        program_strobe_pin_n,
  input  wire logic        external_access_program_voltage_pin,
  input  wire logic        verify_enable_pin,
  input  wire logic        mode_select_a,
  input  wire logic        mode_select_b,
  input  wire logic        mode_select_c,
  input  wire logic [11:0] port_addr,
  input  wire logic [7:0]  port0_in,
  output logic [7:0]       port0_out,
  output logic             port0_oe
);
  localparam int unsigned CW = 15;
  localparam int unsigned PW = 5;

  initial
  begin
    if (PGM_MIN_CYC == 0 || PGM_MIN_CYC > PGM_MAX_CYC ||
        PGM_MAX_CYC >= (1 << CW) || GAP_MIN_CYC == 0 ||
        GAP_MIN_CYC >= (1 << CW) || PULSES == 0 || PULSES >= (1 << PW))
      $error("epv_port: timing parameters out of range");
  end

  function automatic epv_pkg::epv_mode_t epv_decode(
    input epv_pkg::epv_pins_t p
  );
    epv_pkg::epv_mode_t m;
    m = epv_pkg::EPV_IDLE;
    if (p.reset_pin && !p.program_store_enable_pin_n)
    begin
      unique case ({p.verify_enable_pin, p.mode_select_a,
                    p.mode_select_b, p.mode_select_c})
        4'b0000: m = epv_pkg::EPV_SIG;
        4'b1011: m = epv_pkg::EPV_PGM_CODE;
        4'b0011: m = epv_pkg::EPV_VERIFY;
        4'b1010: m = epv_pkg::EPV_PGM_ENC;
        4'b1111: m = epv_pkg::EPV_PGM_SEC1;
        4'b1100: m = epv_pkg::EPV_PGM_SEC2;
        default: m = epv_pkg::EPV_IDLE;
      endcase
    end
    return m;
  endfunction : epv_decode

  // pins are asynchronous to pclk: two flops before any logic
  // reset to an idle strobe so no false edge follows reset
  localparam epv_pkg::epv_pins_t PINS_IDLE = '{program_strobe_pin_n: 1'b1,
                                               default: '0};
  epv_pkg::epv_pins_t pins_raw;
  epv_pkg::epv_pins_t pins_meta_ff;
  epv_pkg::epv_pins_t pins_ff;

  assign pins_raw = '{reset_pin, program_store_enable_pin_n,
                      program_strobe_pin_n,
                      external_access_program_voltage_pin,
                      verify_enable_pin, mode_select_a, mode_select_b,
                      mode_select_c, port_addr, port0_in};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_meta_ff <= PINS_IDLE;
      pins_ff      <= PINS_IDLE;
    end
    else
    begin
      pins_meta_ff <= pins_raw;
      pins_ff      <= pins_meta_ff;
    end
  end

  epv_pkg::epv_mode_t mode;
  epv_pkg::epv_pins_t key_ff;
  logic               strobe_prev_ff;
  logic               fall;
  logic               rise;
  logic               seq_break;
  logic               pgm_mode;

  assign mode      = epv_decode(pins_ff);
  assign fall      = strobe_prev_ff && !pins_ff.program_strobe_pin_n;
  assign rise      = !strobe_prev_ff && pins_ff.program_strobe_pin_n;
  assign pgm_mode  = mode == epv_pkg::EPV_PGM_CODE ||
                     mode == epv_pkg::EPV_PGM_ENC ||
                     mode == epv_pkg::EPV_PGM_SEC1 ||
                     mode == epv_pkg::EPV_PGM_SEC2;
  // a change of address, data or mode starts a fresh sequence
  assign seq_break = {key_ff.verify_enable_pin, key_ff.mode_select_a,
                      key_ff.mode_select_b, key_ff.mode_select_c,
                      key_ff.addr, key_ff.data} !=
                     {pins_ff.verify_enable_pin, pins_ff.mode_select_a,
                      pins_ff.mode_select_b, pins_ff.mode_select_c,
                      pins_ff.addr, pins_ff.data};

  logic [CW-1:0] low_cnt_ff;
  logic [CW-1:0] high_cnt_ff;
  logic [PW-1:0] pulse_cnt_ff;
  logic          commit;
  logic          width_ok;
  logic          gap_bad;
  logic          pulse_ok;

  assign width_ok = low_cnt_ff >= CW'(PGM_MIN_CYC) &&
                    low_cnt_ff <= CW'(PGM_MAX_CYC);
  assign gap_bad  = fall && pulse_cnt_ff != '0 &&
                    high_cnt_ff < CW'(GAP_MIN_CYC);
  assign pulse_ok = rise && pgm_mode && pins_ff.vpp_present && width_ok;
  assign commit   = pulse_ok && pulse_cnt_ff == PW'(PULSES - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strobe_prev_ff <= 1'b1;
      key_ff         <= '0;
      low_cnt_ff     <= '0;
      high_cnt_ff    <= '0;
    end
    else
    begin
      strobe_prev_ff <= pins_ff.program_strobe_pin_n;
      key_ff         <= pins_ff;
      low_cnt_ff     <= pins_ff.program_strobe_pin_n ? '0 :
                        (&low_cnt_ff ? low_cnt_ff : low_cnt_ff + 1'b1);
      high_cnt_ff    <= !pins_ff.program_strobe_pin_n ? '0 :
                        (&high_cnt_ff ? high_cnt_ff : high_cnt_ff + 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_cnt_ff <= '0;
    else if (seq_break || !pgm_mode || commit)
      pulse_cnt_ff <= '0;
    else if (pulse_ok)
      pulse_cnt_ff <= pulse_cnt_ff + 1'b1;
  end

  // apb-side control and status
  logic        inhibit_ff;
  logic        erase_req;
  logic        terr_clr;
  logic        terr_ff;
  logic        erasing_ff;
  logic [11:0] erase_addr_ff;
  logic        sec1_ff;
  logic        sec2_ff;
  logic        enc_done_ff;
  logic [15:0] pcount_ff;
  logic        wr_cyc;
  logic        code_ok;
  logic        enc_ok;

  assign wr_cyc    = psel && penable && pwrite;
  assign erase_req = wr_cyc && paddr == `EPV_OFF_CTRL &&
                     pwdata[`EPV_CTRL_ERASE];
  assign terr_clr  = wr_cyc && paddr == `EPV_OFF_STATUS &&
                     pwdata[`EPV_ST_TERR];
  assign code_ok   = !sec1_ff && !sec2_ff && !inhibit_ff &&
                     !erasing_ff;
  assign enc_ok    = code_ok && pins_ff.addr <= `EPV_ENC_LAST;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      terr_ff <= 1'b0;
    else if ((rise && pgm_mode && !width_ok) || gap_bad)
      terr_ff <= 1'b1; // set wins over a same-cycle clear
    else if (terr_clr)
      terr_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      inhibit_ff <= 1'(`EPV_CTRL_RESET >> `EPV_CTRL_INHIBIT);
    else if (wr_cyc && paddr == `EPV_OFF_CTRL)
      inhibit_ff <= pwdata[`EPV_CTRL_INHIBIT];
  end

  // the array comes up erased: a sweep follows every reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      erasing_ff    <= 1'b1;
      erase_addr_ff <= '0;
    end
    else if (erase_req && !erasing_ff)
    begin
      erasing_ff    <= 1'b1;
      erase_addr_ff <= '0;
    end
    else if (erasing_ff)
    begin
      erasing_ff    <= ~&erase_addr_ff;
      erase_addr_ff <= erase_addr_ff + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec1_ff     <= 1'b0;
      sec2_ff     <= 1'b0;
      enc_done_ff <= 1'b0;
      pcount_ff   <= '0;
    end
    else if (erasing_ff)
    begin
      sec1_ff     <= 1'b0;
      sec2_ff     <= 1'b0;
      enc_done_ff <= 1'b0;
    end
    else if (commit && !inhibit_ff)
    begin
      pcount_ff <= pcount_ff + 1'b1;
      unique case (mode)
        epv_pkg::EPV_PGM_SEC1: sec1_ff <= 1'b1;
        epv_pkg::EPV_PGM_SEC2: sec2_ff <= 1'b1;
        epv_pkg::EPV_PGM_ENC:  enc_done_ff <= enc_done_ff | enc_ok;
        default:               ;
      endcase
    end
  end

  // storage: programming only clears bits, as a real cell does
  logic [7:0] code_mem [0:4095];
  logic [7:0] enc_mem  [0:31];
  logic [7:0] code_rd_ff;
  logic [7:0] enc_rd_ff;

  always_ff @(posedge pclk)
  begin
    if (erasing_ff)
      code_mem[erase_addr_ff] <= `EPV_ERASED;
    else if (commit && code_ok && mode == epv_pkg::EPV_PGM_CODE)
      code_mem[pins_ff.addr] <= code_mem[pins_ff.addr] & pins_ff.data;
    code_rd_ff <= code_mem[pins_ff.addr];
  end

  always_ff @(posedge pclk)
  begin
    if (erasing_ff)
      enc_mem[erase_addr_ff[4:0]] <= `EPV_ERASED;
    else if (commit && enc_ok && mode == epv_pkg::EPV_PGM_ENC)
      enc_mem[pins_ff.addr[4:0]] <= enc_mem[pins_ff.addr[4:0]] &
                                    pins_ff.data;
    enc_rd_ff <= enc_mem[pins_ff.addr[4:0]];
  end

  // port 0 drive; the table byte only ever leaves mixed with code
  logic [7:0] nxt_port0;
  logic       nxt_oe;

  always_comb
  begin
    nxt_port0 = '0;
    nxt_oe    = 1'b0;
    if (mode == epv_pkg::EPV_VERIFY && pins_ff.program_strobe_pin_n &&
        !sec2_ff && !erasing_ff)
    begin
      nxt_oe    = 1'b1;
      nxt_port0 = enc_done_ff ? ~(code_rd_ff ^ enc_rd_ff) :
                                code_rd_ff;
    end
    else if (mode == epv_pkg::EPV_SIG &&
             (pins_ff.addr == `EPV_SIG_LO_ADDR ||
              pins_ff.addr == `EPV_SIG_HI_ADDR))
    begin
      nxt_oe    = 1'b1;
      nxt_port0 = pins_ff.addr[0] ? SIG_HI : SIG_LO;
    end
  end

  logic [7:0] port0_ff;
  logic       oe_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port0_ff <= '0;
      oe_ff    <= 1'b0;
    end
    else
    begin
      port0_ff <= nxt_port0;
      oe_ff    <= nxt_oe;
    end
  end

  assign port0_out = port0_ff;
  assign port0_oe  = oe_ff;

  // apb read data taken in the setup cycle, zero wait states
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        mapped;

  assign mapped = paddr == `EPV_OFF_CTRL || paddr == `EPV_OFF_STATUS ||
                  paddr == `EPV_OFF_PCOUNT;

  always_comb
  begin
    nxt_rdata = '0;
    unique case (paddr)
      `EPV_OFF_CTRL:   nxt_rdata[`EPV_CTRL_INHIBIT] = inhibit_ff;
      `EPV_OFF_STATUS:
      begin
        nxt_rdata[`EPV_ST_SEC1]    = sec1_ff;
        nxt_rdata[`EPV_ST_SEC2]    = sec2_ff;
        nxt_rdata[`EPV_ST_ENC]     = enc_done_ff;
        nxt_rdata[`EPV_ST_ERASING] = erasing_ff;
        nxt_rdata[`EPV_ST_TERR]    = terr_ff;
        nxt_rdata[`EPV_ST_PULSE_LSB +: PW] = pulse_cnt_ff;
        nxt_rdata[`EPV_ST_MODE_LSB +: 3]   = mode;
      end
      `EPV_OFF_PCOUNT: nxt_rdata[15:0] = pcount_ff;
      default:         nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_ff <= '0;
    else if (psel && !penable)
      rdata_ff <= nxt_rdata;
  end

  assign prdata  = rdata_ff;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
endmodule : epv_port

// [test/epv_port_props.sv]
// assertions on the pin side of the eprom program and verify port
`timescale 1ns/100ps
module epv_port_props #(
  parameter logic [7:0] SIG_LO = 8'hA5,
  parameter logic [7:0] SIG_HI = 8'h5A
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  input wire logic        reset_pin,
  input wire logic        program_store_enable_pin_n,
  input wire logic        program_strobe_pin_n,
  input wire logic        verify_enable_pin,
  input wire logic        mode_select_a,
  input wire logic        mode_select_b,
  input wire logic        mode_select_c,
  input wire logic [11:0] port_addr,
  input wire logic [7:0]  port0_out,
  input wire logic        port0_oe
);
  logic sig_mode;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // six samples cover the two sync flops plus the read
  assign sig_mode = reset_pin & ~program_store_enable_pin_n
    & program_strobe_pin_n & ~verify_enable_pin & ~mode_select_a
    & ~mode_select_b & ~mode_select_c;
  property p_sig_lo;
    (sig_mode && port_addr == 12'h030)[*6]
      |-> port0_oe && port0_out == SIG_LO;
  endproperty
  a_sig_lo: assert property (p_sig_lo) else $error("low id byte wrong");
  property p_sig_hi;
    (sig_mode && port_addr == 12'h031)[*6]
      |-> port0_oe && port0_out == SIG_HI;
  endproperty
  a_sig_hi: assert property (p_sig_hi) else $error("high id byte wrong");
  property p_sig_none;
    (sig_mode && port_addr != 12'h030 && port_addr != 12'h031)[*6]
      |-> !port0_oe;
  endproperty
  a_sig_none: assert property (p_sig_none) else $error("id space drove");
  property p_pgm_quiet;
    verify_enable_pin[*5] |-> !port0_oe;
  endproperty
  a_pgm_quiet: assert property (p_pgm_quiet) else $error("driven in pgm");
  property p_release;
    (!reset_pin || !program_strobe_pin_n)[*5] |-> !port0_oe;
  endproperty
  a_release: assert property (p_release) else $error("port not released");
  property p_store_quiet;
    program_store_enable_pin_n[*5] |-> !port0_oe;
  endproperty
  a_store_quiet: assert property (p_store_quiet) else $error("drove, store hi");
  property p_oe_cause;
    $rose(port0_oe)
      |-> $past(reset_pin && !verify_enable_pin && program_strobe_pin_n, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive w/o read");
  c_sig: cover property ($rose(port0_oe) && sig_mode);
  c_ver: cover property ($rose(port0_oe) && mode_select_b);
  c_err: cover property (psel && penable && pslverr);
endmodule : epv_port_props

bind epv_port epv_port_props #(.SIG_LO(SIG_LO), .SIG_HI(SIG_HI)) i_props (
  .pclk, .presetn, .psel, .penable, .pslverr, .reset_pin,
  .program_store_enable_pin_n, .program_strobe_pin_n, .verify_enable_pin,
  .mode_select_a, .mode_select_b, .mode_select_c, .port_addr, .port0_out,
  .port0_oe
);

// [test/epv_programmer.sv]
// model of the external programmer driving mode, address and strobe pins
`timescale 1ns/100ps
module epv_programmer #(
  parameter int LOW_CYC = 25,
  parameter int GAP_CYC = 8,
  parameter int SETUP   = 10
) (
  input  wire logic          pclk,
  input  wire logic [7:0]    port0_out,
  input  wire logic          port0_oe,
  output epv_pkg::epv_pins_t pins
);
  logic [7:0] bus;
  // pull-ups hold port 0 high whenever nobody drives it
  assign bus = port0_oe ? port0_out : 8'hFF;
  initial
  begin
    pins = '0;
    pins.program_strobe_pin_n = 1'b1;
  end
  task automatic set_mode(input logic [3:0] m, input logic [11:0] a,
                          input logic [7:0] d);
    @(posedge pclk);
    pins.reset_pin <= 1'b1;
    pins.program_store_enable_pin_n <= 1'b0;
    pins.program_strobe_pin_n <= 1'b1;
    pins.vpp_present <= 1'b0;
    {pins.verify_enable_pin, pins.mode_select_a, pins.mode_select_b,
     pins.mode_select_c} <= m;
    pins.addr <= a;
    pins.data <= d;
    repeat (SETUP) @(posedge pclk);
  endtask : set_mode
  task automatic burn(input logic [3:0] m, input logic [11:0] a,
                      input logic [7:0] d);
    set_mode(m, a, d);
    pins.vpp_present <= 1'b1;
    repeat (SETUP) @(posedge pclk);
    repeat (25)
    begin
      pins.program_strobe_pin_n <= 1'b0;
      repeat (LOW_CYC) @(posedge pclk);
      pins.program_strobe_pin_n <= 1'b1;
      repeat (GAP_CYC) @(posedge pclk);
    end
    repeat (SETUP) @(posedge pclk);
    pins.vpp_present <= 1'b0;
    @(posedge pclk);
  endtask : burn
  task automatic read(input logic [3:0] m, input logic [11:0] a,
                      output logic [7:0] q);
    set_mode(m, a, 8'h00);
    q = bus;
  endtask : read
endmodule : epv_programmer

// [test/tb.sv]
// self-checking bench for the eprom program and verify port
`timescale 1ns/100ps
module tb;
  localparam logic [3:0] M_SIG  = 4'h0;
  localparam logic [3:0] M_VER  = 4'h3;
  localparam logic [3:0] M_CODE = 4'hB;
  localparam logic [3:0] M_ENC  = 4'hA;
  localparam logic [3:0] M_SEC1 = 4'hF;
  localparam logic [3:0] M_SEC2 = 4'hC;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic [31:0]        rd;
  logic               pready;
  logic               pslverr;
  logic               err;
  logic               port0_oe;
  logic [7:0]         port0_out;
  logic [7:0]         q;
  epv_pkg::epv_pins_t pins;
  int                 miscompares = 0;
  int                 total_checks = 0;
  int                 cycles = 0;
  always #4 pclk = ~pclk;
  epv_port #(.PGM_MIN_CYC(20), .PGM_MAX_CYC(30), .GAP_MIN_CYC(5)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reset_pin(pins.reset_pin),
    .program_store_enable_pin_n(pins.program_store_enable_pin_n),
    .program_strobe_pin_n(pins.program_strobe_pin_n),
    .external_access_program_voltage_pin(pins.vpp_present),
    .verify_enable_pin(pins.verify_enable_pin),
    .mode_select_a(pins.mode_select_a), .mode_select_b(pins.mode_select_b),
    .mode_select_c(pins.mode_select_c), .port_addr(pins.addr),
    .port0_in(pins.data), .port0_out, .port0_oe);
  epv_programmer i_pgm (.pclk, .port0_out, .port0_oe, .pins);
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      close_out();
    end
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd = 32'h8;
    // busy flag covers the erase sweep after reset
    while (rd[3] !== 1'b0) apb(1'b0, 12'h004, 32'h0, rd);
    i_pgm.read(M_VER, 12'h123, q);
    check("erased 123", q, 8'hFF);
    i_pgm.read(M_VER, 12'hFFF, q);
    check("erased FFF", q, 8'hFF);
    i_pgm.read(M_SIG, 12'h030, q);
    check("id lo", q, 8'hA5);
    i_pgm.read(M_SIG, 12'h031, q);
    check("id hi", q, 8'h5A);
    i_pgm.read(M_SIG, 12'h032, q);
    check("id none", q, 8'hFF);
    $display("test erased and id done");
    i_pgm.burn(M_CODE, 12'h005, 8'h3C);
    i_pgm.read(M_VER, 12'h005, q);
    check("code", q, 8'h3C);
    // a second pass can only clear bits
    i_pgm.burn(M_CODE, 12'h005, 8'h0F);
    i_pgm.read(M_VER, 12'h005, q);
    check("code and", q, 8'h0C);
    apb(1'b0, 12'h008, 32'h0, rd);
    check("seq count", rd, 32'h2);
    $display("test code done");
    i_pgm.burn(M_ENC, 12'h005, 8'hF0);
    i_pgm.burn(M_ENC, 12'h025, 8'h00);
    i_pgm.read(M_VER, 12'h005, q);
    check("xnor", q, 8'h03);
    i_pgm.read(M_VER, 12'h006, q);
    check("xnor erased", q, 8'hFF);
    apb(1'b0, 12'h004, 32'h0, rd);
    check("table flag", rd[2], 1'b1);
    apb(1'b0, 12'h000, 32'h0, rd);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0, rd);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("test table and bus done");
    i_pgm.burn(M_SEC1, 12'h000, 8'h00);
    i_pgm.burn(M_CODE, 12'h006, 8'h00);
    i_pgm.read(M_VER, 12'h006, q);
    check("locked code", q, 8'hFF);
    i_pgm.read(M_VER, 12'h005, q);
    check("sec1 read", q, 8'h03);
    i_pgm.burn(M_SEC2, 12'h000, 8'h00);
    apb(1'b0, 12'h004, 32'h0, rd);
    check("sec bits", rd[1:0], 2'h3);
    i_pgm.read(M_VER, 12'h005, q);
    check("sec2 read", q, 8'hFF);
    $display("test security done");
    close_out();
  end
endmodule : tb
